// >>> common/rcf_pkg.sv
// Constants, register layouts and helpers for the receive clock and frame sync generator.
// Assumes a 32-bit AHB-Lite fabric and word-aligned register accesses only.
package rcf_pkg;

   // Register byte offsets
   localparam logic [31:0] RCF_FS_CTRL_OFF = 32'h0000006c;
   localparam logic [31:0] RCF_CLK_CTRL_OFF = 32'h00000070;
   localparam logic [31:0] RCF_FMT_CTRL_OFF = 32'h0000007c;
   localparam logic [31:0] RCF_STATUS_OFF = 32'h00000080;

   // Writable bits; everything else reads zero and ignores writes
   localparam logic [31:0] RCF_FS_CTRL_MASK = 32'h0000ff93;
   localparam logic [31:0] RCF_CLK_CTRL_MASK = 32'h000000bf;
   localparam logic [31:0] RCF_FMT_CTRL_MASK = 32'h000000f0;

   localparam logic [31:0] RCF_FS_CTRL_RST = 32'h00000000;
   localparam logic [31:0] RCF_CLK_CTRL_RST = 32'h00000000;
   localparam logic [31:0] RCF_FMT_CTRL_RST = 32'h000000f0;

   // Frame slot mode codes
   localparam logic [8:0] RCF_MODE_BURST = 9'h000;
   localparam logic [8:0] RCF_MODE_TDM_MIN = 9'h002;
   localparam logic [8:0] RCF_MODE_TDM_MAX = 9'h020;
   localparam logic [8:0] RCF_MODE_384 = 9'h180;
   localparam logic [8:0] RCF_SLOTS_BURST = 9'h001;

   // Slot length codes
   localparam logic [3:0] RCF_SLOT_CODE_MIN = 4'h3;
   localparam logic [5:0] RCF_SLOT_BITS_RSVD = 6'h20;
   localparam logic [5:0] RCF_SLOT_BITS_BASE = 6'h02;

   localparam logic [4:0] RCF_DIV_BYPASS = 5'h00;
   localparam int RCF_HTRANS_ACTIVE_BIT = 1;
   localparam logic RCF_HRESP_OKAY = 1'b0;

   typedef struct packed {
      logic [15:0] rsvd_hi;
      logic [8:0] rx_frame_slot_mode;
      logic [1:0] rsvd_b;
      logic rx_fs_width_select;
      logic [1:0] rsvd_a;
      logic rx_fs_source_select;
      logic rx_fs_polarity;
   } rcf_fs_ctrl_type;

   typedef struct packed {
      logic [23:0] rsvd_hi;
      logic rx_sample_edge_select;
      logic rsvd_a;
      logic rx_bitclk_source_select;
      logic [4:0] rx_bitclk_divide_ratio;
   } rcf_clk_ctrl_type;

   typedef struct packed {
      logic [23:0] rsvd_hi;
      logic [3:0] rx_slot_length;
      logic [3:0] rsvd_lo;
   } rcf_fmt_ctrl_type;

   typedef struct packed {
      logic [20:0] rsvd_hi;
      logic mode_reserved;
      logic slot_reserved;
      logic [8:0] slot_index;
   } rcf_status_type;

   typedef struct packed {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic [31:0] hwdata;
      logic hready;
   } rcf_ahb_req_type;

   typedef struct packed {
      logic rx_bit_clock_pin;
      logic rx_frame_sync_pin;
      logic serial_data_pin;
      logic rx_high_freq_clock;
   } rcf_pin_in_type;

   typedef struct packed {
      logic rx_bit_clock_pin;
      logic bit_clock_oe_n;
      logic rx_frame_sync_pin;
      logic frame_sync_oe_n;
   } rcf_pin_out_type;

   function automatic logic [5:0] rcf_slot_bits(input logic [3:0] code);
      if (code < RCF_SLOT_CODE_MIN || !code[0]) begin
         return RCF_SLOT_BITS_RSVD;
      end
      return {1'b0, code, 1'b0} + RCF_SLOT_BITS_BASE;
   endfunction : rcf_slot_bits

   function automatic logic rcf_mode_reserved(input logic [8:0] m);
      return !((m == RCF_MODE_BURST) || (m == RCF_MODE_384) ||
               (m >= RCF_MODE_TDM_MIN && m <= RCF_MODE_TDM_MAX));
   endfunction : rcf_mode_reserved

endpackage : rcf_pkg

// >>> verilog/rcf_rx_clock_frame_sync_gen.sv
// Receive bit clock and frame sync generator with its AHB-Lite register slave.
// Assumes every pin input is synchronous to core_clk and the high-frequency clock
// is slow enough to be sampled as a level by core_clk.
// What this block does
// - A frame mode of zero selects burst operation with one slot per frame; one is reserved.
// - Frame modes two through thirty-two give frames of that many slots; higher ones up to 17Fh are reserved.
// - Frame mode 180h gives 384-slot frames and every code above it is reserved.
// - The width select makes the active frame sync last one bit when clear and one slot when set.
// - The source select takes the frame sync from the pin when clear and generates it when set.
// - With polarity clear a rising frame sync edge starts a frame, with it set a falling edge does.
// - With the sample edge select clear data are sampled on the falling bit clock edge, else on the rising.
// - The bit clock source takes the clock from the pin when clear and from the divider when set.
// - The divide field sets the high-frequency to bit clock ratio as the field value plus one.
// - Reserved bits of the control registers read as zero and ignore writes.
// - The slot length code gives 8 bits at 3h rising by four bits per odd code to 32 at Fh.
// - With an internal bit clock at divide-by-1 the high-frequency clock passes straight to the pin.
`timescale 1ns/100ps
module rcf_rx_clock_frame_sync_gen (
   input wire logic core_clk,
   input wire logic nrst,
   input wire rcf_pkg::rcf_ahb_req_type ahb_req,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire rcf_pkg::rcf_pin_in_type pin_in,
   output rcf_pkg::rcf_pin_out_type pin_out,
   output logic frame_start,
   output logic rx_bit,
   output logic rx_bit_valid
);
   import rcf_pkg::*;

   logic rst_meta_q;
   logic rst_n_q;

   // Reset release only; assertion stays asynchronous
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q <= rst_meta_q;
      end
   end

   // Bus slave
   logic wr_pend_q;
   logic [31:0] wr_addr_q;
   logic [31:0] hrdata_q;
   rcf_fs_ctrl_type fs_q;
   rcf_fs_ctrl_type fs_d;
   rcf_clk_ctrl_type clk_q;
   rcf_clk_ctrl_type clk_d;
   rcf_fmt_ctrl_type fmt_q;
   rcf_fmt_ctrl_type fmt_d;
   rcf_status_type status_d;
   logic [8:0] gen_slot_q;
   logic [5:0] gen_bit_q;

   wire addr_phase = ahb_req.hsel && ahb_req.htrans[RCF_HTRANS_ACTIVE_BIT] && ahb_req.hready;
   wire wr_fs = wr_pend_q && (wr_addr_q == RCF_FS_CTRL_OFF);
   wire wr_clk = wr_pend_q && (wr_addr_q == RCF_CLK_CTRL_OFF);
   wire wr_fmt = wr_pend_q && (wr_addr_q == RCF_FMT_CTRL_OFF);

   // Reserved bits are masked on the way in, so they always read zero
   assign fs_d = wr_fs ? rcf_fs_ctrl_type'(ahb_req.hwdata & RCF_FS_CTRL_MASK) : fs_q;
   assign clk_d = wr_clk ? rcf_clk_ctrl_type'(ahb_req.hwdata & RCF_CLK_CTRL_MASK) : clk_q;
   assign fmt_d = wr_fmt ? rcf_fmt_ctrl_type'(ahb_req.hwdata & RCF_FMT_CTRL_MASK) : fmt_q;

   wire mode_rsvd = rcf_mode_reserved(fs_q.rx_frame_slot_mode);
   wire slot_rsvd = (fmt_q.rx_slot_length < RCF_SLOT_CODE_MIN) || !fmt_q.rx_slot_length[0];
   assign status_d = '{rsvd_hi: '0, mode_reserved: mode_rsvd, slot_reserved: slot_rsvd,
                       slot_index: gen_slot_q};

   // Read mux looks at next values so a write followed by a read of the same word is fresh
   wire [31:0] rd_mux =
      (ahb_req.haddr == RCF_FS_CTRL_OFF) ? 32'(fs_d) :
      (ahb_req.haddr == RCF_CLK_CTRL_OFF) ? 32'(clk_d) :
      (ahb_req.haddr == RCF_FMT_CTRL_OFF) ? 32'(fmt_d) :
      (ahb_req.haddr == RCF_STATUS_OFF) ? 32'(status_d) : 32'h00000000;

   always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 32'h00000000;
         hrdata_q <= 32'h00000000;
         fs_q <= rcf_fs_ctrl_type'(RCF_FS_CTRL_RST);
         clk_q <= rcf_clk_ctrl_type'(RCF_CLK_CTRL_RST);
         fmt_q <= rcf_fmt_ctrl_type'(RCF_FMT_CTRL_RST);
      end else begin
         wr_pend_q <= addr_phase && ahb_req.hwrite;
         wr_addr_q <= ahb_req.haddr;
         if (addr_phase && !ahb_req.hwrite) begin
            hrdata_q <= rd_mux;
         end
         fs_q <= fs_d;
         clk_q <= clk_d;
         fmt_q <= fmt_d;
      end
   end

   // Zero wait states, always OKAY
   assign hreadyout = rst_n_q;
   assign hresp = RCF_HRESP_OKAY;
   assign hrdata = hrdata_q;

   // Bit clock divider, counts high-frequency rising edges
   logic hf_prev_q;
   logic [4:0] div_cnt_q;
   logic [4:0] div_cnt_d;
   logic bclk_out_q;
   logic bclk_prev_q;

   wire [4:0] div = clk_q.rx_bitclk_divide_ratio;
   wire hf_rise = pin_in.rx_high_freq_clock && !hf_prev_q;
   wire [5:0] div_half = ({1'b0, div} + 6'h02) >> 1;
   assign div_cnt_d = !hf_rise ? div_cnt_q :
                      (div_cnt_q >= div) ? 5'h00 : div_cnt_q + 5'h01;
   // Bypass copies the high-frequency level straight out
   wire bclk_gen = (div == RCF_DIV_BYPASS) ? pin_in.rx_high_freq_clock :
                   ({1'b0, div_cnt_d} < div_half);
   wire bclk_lvl = clk_q.rx_bitclk_source_select ? bclk_out_q : pin_in.rx_bit_clock_pin;
   wire bclk_rise = bclk_lvl && !bclk_prev_q;
   wire bclk_fall = !bclk_lvl && bclk_prev_q;
   wire sample_edge = clk_q.rx_sample_edge_select ? bclk_rise : bclk_fall;
   wire launch_edge = clk_q.rx_sample_edge_select ? bclk_fall : bclk_rise;

   // Frame sync generator, advances on the launch edge so the far end samples it cleanly
   logic [8:0] gen_slot_d;
   logic [5:0] gen_bit_d;
   wire [5:0] slot_last = rcf_slot_bits(fmt_q.rx_slot_length) - 6'h01;
   wire [8:0] slot_mode = fs_q.rx_frame_slot_mode;
   wire [8:0] frame_slots = (slot_mode == RCF_MODE_BURST) ? RCF_SLOTS_BURST : slot_mode;
   wire bit_wrap = (gen_bit_q >= slot_last);
   wire slot_wrap = (gen_slot_q >= frame_slots - 9'h001);

   // A reserved mode parks the generator with the frame sync inactive
   assign gen_bit_d = mode_rsvd ? 6'h00 : !launch_edge ? gen_bit_q :
                      bit_wrap ? 6'h00 : gen_bit_q + 6'h01;
   assign gen_slot_d = mode_rsvd ? 9'h000 : !(launch_edge && bit_wrap) ? gen_slot_q :
                       slot_wrap ? 9'h000 : gen_slot_q + 9'h001;
   wire fs_active_d = !mode_rsvd && (gen_slot_d == 9'h000) &&
                      (fs_q.rx_fs_width_select || (gen_bit_d == 6'h00));
   wire fs_gen_lvl = fs_active_d ^ fs_q.rx_fs_polarity;

   // Frame start detection on the sampling edge
   logic fs_prev_q;
   logic frame_start_q;
   logic rx_bit_q;
   logic rx_bit_valid_q;
   rcf_pin_out_type pin_out_q;
   wire fs_lvl = fs_q.rx_fs_source_select ? pin_out_q.rx_frame_sync_pin :
                 pin_in.rx_frame_sync_pin;
   wire fs_act = fs_lvl ^ fs_q.rx_fs_polarity;
   wire fs_prev_act = fs_prev_q ^ fs_q.rx_fs_polarity;
   wire fs_start = sample_edge && fs_act && !fs_prev_act;

   always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         hf_prev_q <= 1'b0;
         div_cnt_q <= 5'h00;
         bclk_out_q <= 1'b0;
         bclk_prev_q <= 1'b0;
         gen_bit_q <= 6'h00;
         gen_slot_q <= 9'h000;
         fs_prev_q <= 1'b0;
         frame_start_q <= 1'b0;
         rx_bit_q <= 1'b0;
         rx_bit_valid_q <= 1'b0;
         pin_out_q <= '{rx_bit_clock_pin: 1'b0, bit_clock_oe_n: 1'b1,
                        rx_frame_sync_pin: 1'b0, frame_sync_oe_n: 1'b1};
      end else begin
         hf_prev_q <= pin_in.rx_high_freq_clock;
         div_cnt_q <= div_cnt_d;
         bclk_out_q <= bclk_gen;
         bclk_prev_q <= bclk_lvl;
         gen_bit_q <= gen_bit_d;
         gen_slot_q <= gen_slot_d;
         if (sample_edge) begin
            fs_prev_q <= fs_lvl;
         end
         frame_start_q <= fs_start;
         rx_bit_valid_q <= sample_edge;
         if (sample_edge) begin
            rx_bit_q <= pin_in.serial_data_pin;
         end
         pin_out_q.rx_bit_clock_pin <= bclk_gen;
         pin_out_q.bit_clock_oe_n <= !clk_q.rx_bitclk_source_select;
         pin_out_q.rx_frame_sync_pin <= fs_gen_lvl;
         pin_out_q.frame_sync_oe_n <= !fs_q.rx_fs_source_select;
      end
   end

   assign pin_out = pin_out_q;
   assign frame_start = frame_start_q;
   assign rx_bit = rx_bit_q;
   assign rx_bit_valid = rx_bit_valid_q;

   a_reserved_reads_zero: assert property (@(posedge core_clk) disable iff (!rst_n_q)
      ((32'(fs_q) & ~RCF_FS_CTRL_MASK) == 32'h00000000) &&
      ((32'(clk_q) & ~RCF_CLK_CTRL_MASK) == 32'h00000000))
      else $error("reserved control bits not zero");

   a_pin_drive_enable: assert property (@(posedge core_clk) disable iff (!rst_n_q)
      ##1 (pin_out_q.bit_clock_oe_n == !$past(clk_q.rx_bitclk_source_select)) &&
      (pin_out_q.frame_sync_oe_n == !$past(fs_q.rx_fs_source_select)))
      else $error("pin drive enable does not follow source select");

   a_hf_pass_through: assert property (@(posedge core_clk) disable iff (!rst_n_q)
      (clk_q.rx_bitclk_divide_ratio == RCF_DIV_BYPASS) |=>
      (pin_out_q.rx_bit_clock_pin == $past(pin_in.rx_high_freq_clock)))
      else $error("divide-by-1 does not pass the high-frequency clock");

   a_divider_wrap: assert property (@(posedge core_clk) disable iff (!rst_n_q)
      (hf_rise && (div_cnt_q == div) && !wr_clk) |=> (div_cnt_q == 5'h00))
      else $error("divider does not wrap at its ratio");

   a_sample_on_edge: assert property (@(posedge core_clk) disable iff (!rst_n_q)
      rx_bit_valid_q |-> $past(clk_q.rx_sample_edge_select ? bclk_rise : bclk_fall))
      else $error("sample taken on the wrong bit clock edge");

   a_frame_start_edge: assert property (@(posedge core_clk) disable iff (!rst_n_q)
      frame_start_q |-> $past(sample_edge) && $past(fs_act) && !$past(fs_prev_act))
      else $error("frame start without a start edge");

   a_fs_single_bit: assert property (@(posedge core_clk) disable iff (!rst_n_q)
      (!fs_q.rx_fs_width_select && (gen_bit_d != 6'h00)) |=>
      (pin_out_q.rx_frame_sync_pin == $past(fs_q.rx_fs_polarity)))
      else $error("single-bit frame sync active past the first bit");

   // A mid-frame change to burst mode lets the current slot run out before slot zero
   a_burst_one_slot: assert property (@(posedge core_clk) disable iff (!rst_n_q)
      (slot_mode == RCF_MODE_BURST) && ((gen_slot_q == 9'h000) || (launch_edge && bit_wrap))
      |=> (gen_slot_q == 9'h000))
      else $error("burst mode left slot zero");

   a_tdm_frame_wrap: assert property (@(posedge core_clk) disable iff (!rst_n_q)
      (launch_edge && bit_wrap && (gen_slot_q == frame_slots - 9'h001) && !mode_rsvd)
      |=> (gen_slot_q == 9'h000))
      else $error("frame did not wrap after its last slot");

   a_slot_length_wrap: assert property (@(posedge core_clk) disable iff (!rst_n_q)
      (launch_edge && (gen_bit_q == slot_last)) |=> (gen_bit_q == 6'h00))
      else $error("slot did not wrap at its length");

   // Writes land at the edge that closes the data phase, masked on the way in
   a_fs_write_lands: assert property (@(posedge core_clk) disable iff (!rst_n_q)
      wr_fs |=> (32'(fs_q) == ($past(ahb_req.hwdata) & RCF_FS_CTRL_MASK)))
      else $error("frame sync control write not stored");

   a_clk_write_lands: assert property (@(posedge core_clk) disable iff (!rst_n_q)
      wr_clk |=> (32'(clk_q) == ($past(ahb_req.hwdata) & RCF_CLK_CTRL_MASK)))
      else $error("bit clock control write not stored");

   a_unmapped_reads_zero: assert property (@(posedge core_clk) disable iff (!rst_n_q)
      (addr_phase && !ahb_req.hwrite && (ahb_req.haddr != RCF_FS_CTRL_OFF) &&
       (ahb_req.haddr != RCF_CLK_CTRL_OFF) && (ahb_req.haddr != RCF_FMT_CTRL_OFF) &&
       (ahb_req.haddr != RCF_STATUS_OFF)) |=> (hrdata_q == 32'h00000000))
      else $error("unmapped read not zero");

   // A reserved mode must never leave a stray frame sync on the pin
   a_reserved_mode_park: assert property (@(posedge core_clk) disable iff (!rst_n_q)
      mode_rsvd |=> (gen_bit_q == 6'h00) && (gen_slot_q == 9'h000) &&
      (pin_out_q.rx_frame_sync_pin == $past(fs_q.rx_fs_polarity)))
      else $error("reserved frame mode did not park the generator");

   a_fs_word_width: assert property (@(posedge core_clk) disable iff (!rst_n_q)
      (fs_q.rx_fs_width_select && !mode_rsvd && (gen_slot_d == 9'h000)) |=>
      (pin_out_q.rx_frame_sync_pin != $past(fs_q.rx_fs_polarity)))
      else $error("word-wide frame sync not active through slot zero");

   a_fs_pin_sampled: assert property (@(posedge core_clk) disable iff (!rst_n_q)
      (!fs_q.rx_fs_source_select && sample_edge) |=> (fs_prev_q == $past(pin_in.rx_frame_sync_pin)))
      else $error("external frame sync not taken from the pin");

   // Start detection keys on sampled levels, so a pulse between edges is lost
   a_frame_start_seen: assert property (@(posedge core_clk) disable iff (!rst_n_q)
      (sample_edge && fs_act && !fs_prev_act) |=> frame_start_q)
      else $error("frame start edge missed");

   a_data_capture: assert property (@(posedge core_clk) disable iff (!rst_n_q)
      sample_edge |=> rx_bit_valid_q && (rx_bit_q == $past(pin_in.serial_data_pin)))
      else $error("data bit not taken on the sampling edge");

   // Between sampling edges the bit stands, so a launch-edge glitch is never seen
   a_bit_holds: assert property (@(posedge core_clk) disable iff (!rst_n_q)
      !sample_edge |=> !rx_bit_valid_q && $stable(rx_bit_q))
      else $error("data bit changed off the sampling edge");

   // No synchroniser on the pin path: pins are taken as synchronous to core_clk
   a_bclk_from_pin: assert property (@(posedge core_clk) disable iff (!rst_n_q)
      !clk_q.rx_bitclk_source_select |=> (bclk_prev_q == $past(pin_in.rx_bit_clock_pin)))
      else $error("external bit clock not taken from the pin");

   a_bclk_from_divider: assert property (@(posedge core_clk) disable iff (!rst_n_q)
      clk_q.rx_bitclk_source_select |=> (bclk_prev_q == $past(bclk_out_q)))
      else $error("internal bit clock not taken from the divider");

endmodule : rcf_rx_clock_frame_sync_gen

// >>> verif/rcf_audio_src_model.sv
// Behavioural audio source driving the receive bit clock, frame sync and data pins.
// Assumes a free core clock; one bit every eight core cycles while run is high.
`timescale 1ns/100ps
module rcf_audio_src_model (
   input wire logic core_clk,
   input wire logic run,
   input wire logic launch_fall,
   input wire logic fs_low_active,
   output logic bclk,
   output logic fs,
   output logic sd = 1'b0,
   output logic cur_bit = 1'b0,
   output logic [2:0] bit_idx
);
   logic [1:0] ph_q = 2'h0;
   logic [15:0] pat_q = 16'hc35a;
   wire launch = (ph_q == 2'h3) && (bclk == launch_fall);
   always @(posedge core_clk) begin
      if (!run) begin
         // Clock stands still while run is low, data line is not held
         ph_q <= 2'h0;
         bclk <= 1'b0;
         fs <= fs_low_active;
         sd <= ~sd;
         bit_idx <= 3'h7;
      end else begin
         ph_q <= ph_q + 2'h1;
         // A launch puts a wrong level out for one cycle, so a launch-edge sample fails
         sd <= launch ? ~pat_q[0] : cur_bit;
         if (ph_q == 2'h3) begin
            bclk <= ~bclk;
         end
         if (launch) begin
            bit_idx <= bit_idx + 3'h1;
            fs <= (bit_idx == 3'h7) ^ fs_low_active;
            cur_bit <= pat_q[0];
            pat_q <= {pat_q[0], pat_q[15:1]};
         end
      end
   end
endmodule : rcf_audio_src_model

// >>> verif/tb_rcf_rx_clock_frame_sync_gen.sv
// Self-checking bench: AHB-Lite register tasks plus an external audio source.
// Assumes the high-frequency clock comes from a core clock counter.
`timescale 1ns/100ps
module tb_rcf_rx_clock_frame_sync_gen;
   import rcf_pkg::*;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic sel = 1'b0;
   logic wr = 1'b0;
   logic [1:0] trans = 2'h0;
   logic [31:0] addr = 32'h0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] hf_q = 4'h0;
   logic run = 1'b0;
   logic launch_fall = 1'b0;
   logic fs_low = 1'b0;
   logic mon = 1'b0;
   logic bclk, fs, sd, cur_bit, hreadyout, hresp, frame_start, rx_bit, rx_bit_valid;
   logic [2:0] bit_idx;
   logic [31:0] hrdata, rd;
   rcf_ahb_req_type ahb_req;
   rcf_pin_in_type pin_in;
   rcf_pin_out_type pin_out;
   int fail_count = 0;
   int comparisons = 0;
   int nvalid, nfs, n;
   logic [9:0] mtab [9] = '{10'h000, 10'h201, 10'h002, 10'h020, 10'h221, 10'h37f, 10'h180,
                            10'h381, 10'h3ff};
   logic [4:0] dtab [4] = '{5'h00, 5'h01, 5'h04, 5'h1f};
   logic [10:0] fcfg [7] = '{11'h008, 11'h00a, 11'h009, 11'h000, 11'h080, 11'h602, 11'h084};
   int fwin [7] = '{128, 128, 128, 128, 1024, 12288, 128};
   int fexp [7] = '{8, 64, 8, 16, 4, 32, 0};
   assign ahb_req = {sel, addr, trans, wr, 3'h2, wdata, hreadyout};
   assign pin_in = {bclk, fs, sd, hf_q[1]};
   always #10 core_clk = ~core_clk;
   always @(posedge core_clk) hf_q <= hf_q + 4'h1;

   rcf_rx_clock_frame_sync_gen i_rcf_rx_clock_frame_sync_gen (.core_clk(core_clk),
      .nrst(nrst), .ahb_req(ahb_req), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .pin_in(pin_in), .pin_out(pin_out), .frame_start(frame_start), .rx_bit(rx_bit),
      .rx_bit_valid(rx_bit_valid));
   rcf_audio_src_model i_rcf_audio_src_model (.core_clk(core_clk), .run(run),
      .launch_fall(launch_fall), .fs_low_active(fs_low), .bclk(bclk), .fs(fs), .sd(sd),
      .cur_bit(cur_bit), .bit_idx(bit_idx));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic give_verdict;
      $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : give_verdict

   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      sel <= 1'b1;
      addr <= a;
      trans <= 2'h2;
      wr <= w;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      sel <= 1'b0;
      trans <= 2'h0;
      wdata <= d;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus

   task automatic count_lvl(input int cycles, input logic lvl, output int c);
      c = 0;
      repeat (cycles) begin
         @(posedge core_clk);
         if (pin_out.rx_frame_sync_pin === lvl) c++;
      end
   endtask : count_lvl

   task automatic period(output int p);
      realtime t0;
      @(posedge pin_out.rx_bit_clock_pin);
      t0 = $realtime;
      @(posedge pin_out.rx_bit_clock_pin);
      p = int'(($realtime - t0) / 20.0);
   endtask : period

   always @(posedge core_clk) begin
      if (mon) begin
         if (rx_bit_valid === 1'b1) begin
            nvalid++;
            check(rx_bit, cur_bit);
         end
         if (frame_start === 1'b1) begin
            nfs++;
            check(bit_idx, 0);
         end
      end
   end

   initial begin
      repeat (5) @(posedge core_clk);
      nrst <= 1'b1;
      repeat (3) @(posedge core_clk);
      check({pin_out.bit_clock_oe_n, pin_out.frame_sync_oe_n}, 2'b11);
      bus(1'b0, 32'h6c, 0);
      check(rd, 32'h0);
      bus(1'b0, 32'h70, 0);
      check(rd, 32'h0);
      bus(1'b0, 32'h7c, 0);
      check(rd, 32'hf0);
      bus(1'b1, 32'h6c, 32'hffffffff);
      bus(1'b0, 32'h6c, 0);
      check(rd, 32'h0000ff93);
      bus(1'b1, 32'h70, 32'hffffffff);
      bus(1'b0, 32'h70, 0);
      check(rd, 32'h000000bf);
      bus(1'b1, 32'h84, 32'hffffffff);
      bus(1'b0, 32'h84, 0);
      check(rd, 32'h0);
      check({30'h0, hreadyout, hresp}, 32'h2);
      foreach (mtab[i]) begin
         bus(1'b1, 32'h6c, {16'h0, mtab[i][8:0], 7'h0});
         bus(1'b0, 32'h80, 0);
         check(rd[10], mtab[i][9]);
      end
      for (int k = 0; k < 16; k++) begin
         bus(1'b1, 32'h7c, {24'h0, 4'(k), 4'h0});
         bus(1'b0, 32'h80, 0);
         check(rd[9], !(k >= 3 && k % 2 == 1));
      end
      foreach (dtab[i]) begin
         bus(1'b1, 32'h70, {24'h0, 3'h1, dtab[i]});
         period(n);
         period(n);
         check(n, (int'(dtab[i]) + 1) * 4);
         check(pin_out.bit_clock_oe_n, 1'b0);
      end
      bus(1'b1, 32'h70, 32'h20);
      repeat (8) begin
         #1;
         n = hf_q[1];
         @(posedge core_clk);
         #1;
         check(pin_out.rx_bit_clock_pin, n);
      end
      @(posedge core_clk);
      // Short 8-bit slots keep the 384-slot frame to 12288 cycles
      bus(1'b1, 32'h7c, 32'h30);
      foreach (fcfg[i]) begin
         bus(1'b1, 32'h6c, {16'h0, fcfg[i][10:2], 2'h0, fcfg[i][1], 2'h0, 1'b1, fcfg[i][0]});
         count_lvl(fwin[i], !fcfg[i][0], n);
         count_lvl(fwin[i], !fcfg[i][0], n);
         check(n, fexp[i]);
         check(pin_out.frame_sync_oe_n, 1'b0);
      end
      for (int e = 0; e < 2; e++) begin
         bus(1'b1, 32'h70, {24'h0, 1'(e), 7'h0});
         bus(1'b1, 32'h6c, {16'h0, 9'h002, 6'h0, 1'(e)});
         launch_fall <= 1'(e);
         fs_low <= 1'(e);
         run <= 1'b1;
         repeat (128) @(posedge core_clk);
         nvalid = 0;
         nfs = 0;
         mon <= 1'b1;
         repeat (256) @(posedge core_clk);
         mon <= 1'b0;
         run <= 1'b0;
         @(posedge core_clk);
         check(nvalid, 32);
         check(nfs, 4);
         check({pin_out.bit_clock_oe_n, pin_out.frame_sync_oe_n}, 2'b11);
      end
      give_verdict();
   end

   // Tests need about 29500 cycles
   initial begin
      #(60000 * 20);
      fail_count++;
      give_verdict();
   end
endmodule : tb_rcf_rx_clock_frame_sync_gen
